// ### include/tptis_pkg.sv
// Package: constants for the path trace indirect message store
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// (RL1) Location 0 config, 1..3Fh invalid, 40h+ bytes
// (RL2) Address register write starts one transfer
// (RL3) Read copies RAM word into data register
// (RL4) Write copies data register into RAM
// (RL5) Busy set on address write, cleared after
// (RL6) Transfer finishes within 22 link cycles
// (RL7) Software polls busy before taking read data
// (RL8) Software loads data before starting write
// (RL9) Sixteen bit data register, resets to zero
// (RL10) Short select gives 16, else 64 bytes
// (RL11) Single byte option overrides short select
// (RL12) All zero option sends zero message
// (RL13) All zero change applies at once
// (RL14) Message bytes read from 40h upward
// (RL15) Config bits: zero 2, single 1, short 0
// (RL16) Trace byte in bits 7..0 only
// (RL17) Data register at instance offset 10E1h
// (RL18) Path codes 1..12 valid, others invalid
// (RL19) Address register fields: busy, rnw, loc, path
// (RL20) Invalid path/location leaves RAM unchanged
// (RL21) Bytes sent ascending, repeating, per slot
package tptis_pkg;
	localparam logic [15:0] TPTIS_ADDR_OFS = 16'h10e0;
	localparam logic [15:0] TPTIS_DATA_OFS = 16'h10e1;
	localparam logic [15:0] TPTIS_INST_STRIDE = 16'h0400;
	localparam logic [1:0] TPTIS_WORD_SHIFT = 2'h2;
	localparam int TPTIS_BUSY_BIT = 15;
	localparam int TPTIS_RNW_BIT = 14;
	localparam int TPTIS_LOC_HI = 12;
	localparam int TPTIS_LOC_LO = 6;
	localparam int TPTIS_PATH_HI = 3;
	localparam int TPTIS_PATH_LO = 0;
	localparam int TPTIS_CFG_ZERO = 2;
	localparam int TPTIS_CFG_SINGLE = 1;
	localparam int TPTIS_CFG_SHORT = 0;
	localparam logic [6:0] TPTIS_LOC_CFG = 7'h00;
	localparam logic [6:0] TPTIS_LOC_MSG = 7'h40;
	localparam logic [3:0] TPTIS_PATH_MIN = 4'h1;
	localparam logic [3:0] TPTIS_PATH_MAX = 4'hc;
	localparam logic [15:0] TPTIS_DATA_RST = 16'h0000;
	localparam logic [2:0] TPTIS_CFG_RST = 3'h0;
	localparam logic [5:0] TPTIS_LEN_1 = 6'h00;
	localparam logic [5:0] TPTIS_LEN_16 = 6'h0f;
	localparam logic [5:0] TPTIS_LEN_64 = 6'h3f;
	localparam int TPTIS_MAX_BUSY = 22;
	localparam logic [4:0] TPTIS_XFER_CYC = 5'h03;
	typedef enum logic [1:0] {
		TPTIS_IDLE = 2'b00,
		TPTIS_ACCESS = 2'b01,
		TPTIS_DONE = 2'b10
	} tptis_state_t;
endpackage

// ### hw/tptis_store.sv
// Indirect trace store with Wishbone slave and trace byte stream
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module tptis_store #(
	parameter int NUM_PATHS = 12,
	parameter logic [1:0] INSTANCE = 2'h0
) (
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [15:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic TRACE_SLOT_I,
	input wire logic [3:0] TRACE_PATH_I,
	output logic [7:0] TRACE_BYTE_O,
	output logic TRACE_VALID_O
);
	//------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------
	wire logic [15:0] base_ofs = tptis_pkg::TPTIS_ADDR_OFS
		+ 16'(INSTANCE) * tptis_pkg::TPTIS_INST_STRIDE;
	wire logic [15:0] word_idx = WB_ADR_I >> tptis_pkg::TPTIS_WORD_SHIFT;
	wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire logic hit_addr = word_idx == base_ofs;
	wire logic hit_data = word_idx == base_ofs + 16'h0001; // [RL17]
	wire logic lo_sel = WB_SEL_I[0] && WB_SEL_I[1];
	wire logic wr_addr = req && WB_WE_I && hit_addr && lo_sel; // [RL2]
	wire logic wr_data = req && WB_WE_I && hit_data && lo_sel;

	tptis_pkg::tptis_state_t state_reg, state_next;
	logic [15:0] data_reg;
	logic rnw_reg;
	logic [6:0] loc_reg;
	logic [3:0] path_reg;
	logic [4:0] cnt_reg;
	logic busy;
	logic [2:0] cfg_mem [1:NUM_PATHS];
	logic [7:0] msg_mem [0:NUM_PATHS*64-1];

	wire logic path_ok = path_reg >= tptis_pkg::TPTIS_PATH_MIN
		&& path_reg <= tptis_pkg::TPTIS_PATH_MAX; // [RL18]
	wire logic is_cfg = loc_reg == tptis_pkg::TPTIS_LOC_CFG; // [RL1]
	wire logic is_msg = loc_reg[6]; // [RL1]
	wire logic [3:0] pidx = path_ok ? path_reg : 4'h1;
	wire logic [9:0] midx = 10'(({6'h00, pidx} - 10'h001) * 10'h040)
		+ {4'h0, loc_reg[5:0]};
	wire logic [15:0] rd_word = is_cfg ? {13'h0000, cfg_mem[pidx]}
		: is_msg ? {8'h00, msg_mem[midx]} : 16'h0000; // [RL16]
	wire logic fin = state_reg == tptis_pkg::TPTIS_DONE;

	assign busy = state_reg != tptis_pkg::TPTIS_IDLE; // [RL5]

	//------------------------------------------------------------
	// Wishbone answer
	//------------------------------------------------------------
	wire logic [15:0] addr_view = {busy, rnw_reg, 1'b0, loc_reg, 2'b00,
		path_reg}; // [RL19]
	wire logic [15:0] rd_mux = hit_addr ? addr_view
		: hit_data ? data_reg : 16'h0000;

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= req;
			WB_DAT_O <= {16'h0000, rd_mux};
		end
	end

	//------------------------------------------------------------
	// Indirect transfer engine
	//------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			tptis_pkg::TPTIS_IDLE: begin
				if (wr_addr) begin
					state_next = tptis_pkg::TPTIS_ACCESS;
				end
			end
			tptis_pkg::TPTIS_ACCESS: begin
				if (cnt_reg == tptis_pkg::TPTIS_XFER_CYC) begin // [RL6]
					state_next = tptis_pkg::TPTIS_DONE;
				end
			end
			tptis_pkg::TPTIS_DONE: state_next = tptis_pkg::TPTIS_IDLE;
			default: state_next = tptis_pkg::TPTIS_IDLE;
		endcase
	end

	// New address writes while busy are ignored to keep the access whole
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			state_reg <= tptis_pkg::TPTIS_IDLE;
			rnw_reg <= 1'b0;
			loc_reg <= 7'h00;
			path_reg <= 4'h0;
			cnt_reg <= 5'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg <= (state_reg == tptis_pkg::TPTIS_ACCESS)
				? cnt_reg + 5'h01 : 5'h00;
			if (wr_addr && !busy) begin
				rnw_reg <= WB_DAT_I[tptis_pkg::TPTIS_RNW_BIT];
				loc_reg <= WB_DAT_I[tptis_pkg::TPTIS_LOC_HI:
					tptis_pkg::TPTIS_LOC_LO];
				path_reg <= WB_DAT_I[tptis_pkg::TPTIS_PATH_HI:
					tptis_pkg::TPTIS_PATH_LO];
			end
		end
	end

	// Data register: bus writes blocked while busy so a read result lands
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			data_reg <= tptis_pkg::TPTIS_DATA_RST; // [RL9]
		end else if (fin && rnw_reg) begin
			data_reg <= (path_ok && (is_cfg || is_msg))
				? rd_word : data_reg; // [RL3]
		end else if (wr_data && !busy) begin
			data_reg <= WB_DAT_I[15:0];
		end
	end

	// Message RAM has no reset; only config is cleared
	always_ff @(posedge SYS_CLK_I) begin
		if (fin && !rnw_reg && path_ok && is_msg) begin
			msg_mem[midx] <= data_reg[7:0]; // [RL4] [RL16] [RL20]
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			for (int i = 1; i <= NUM_PATHS; i++) begin
				cfg_mem[i] <= tptis_pkg::TPTIS_CFG_RST;
			end
		end else if (fin && !rnw_reg && path_ok && is_cfg) begin
			cfg_mem[pidx] <= data_reg[2:0]; // [RL4] [RL15] [RL20]
		end
	end

	//------------------------------------------------------------
	// Trace stream
	//------------------------------------------------------------
	logic [5:0] pos_reg [1:NUM_PATHS];
	wire logic tp_ok = TRACE_PATH_I >= tptis_pkg::TPTIS_PATH_MIN
		&& TRACE_PATH_I <= tptis_pkg::TPTIS_PATH_MAX;
	wire logic [3:0] tidx = tp_ok ? TRACE_PATH_I : 4'h1;
	wire logic [2:0] tcfg = cfg_mem[tidx];
	wire logic [5:0] last = tcfg[tptis_pkg::TPTIS_CFG_SINGLE]
		? tptis_pkg::TPTIS_LEN_1
		: tcfg[tptis_pkg::TPTIS_CFG_SHORT] ? tptis_pkg::TPTIS_LEN_16
		: tptis_pkg::TPTIS_LEN_64; // [RL10] [RL11]
	wire logic [5:0] tpos = (pos_reg[tidx] > last) ? 6'h00 : pos_reg[tidx];
	wire logic [9:0] tmi = 10'(({6'h00, tidx} - 10'h001) * 10'h040)
		+ {4'h0, tpos}; // [RL14]

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			for (int i = 1; i <= NUM_PATHS; i++) begin
				pos_reg[i] <= 6'h00;
			end
			TRACE_BYTE_O <= 8'h00;
			TRACE_VALID_O <= 1'b0;
		end else begin
			TRACE_VALID_O <= TRACE_SLOT_I && tp_ok;
			if (TRACE_SLOT_I && tp_ok) begin
				// Zero override is not held to a message boundary
				TRACE_BYTE_O <= tcfg[tptis_pkg::TPTIS_CFG_ZERO]
					? 8'h00 : msg_mem[tmi]; // [RL12] [RL13]
				pos_reg[tidx] <= (tpos == last) ? 6'h00
					: tpos + 6'h01; // [RL21]
			end
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	logic [5:0] busy_cnt;
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			busy_cnt <= 6'h00;
		end else begin
			busy_cnt <= busy ? busy_cnt + 6'h01 : 6'h00;
		end
	end

	chk_busy_bound: assert property (@(posedge SYS_CLK_I) // [RL6]
		disable iff (SYS_RST_I) busy_cnt < 6'(tptis_pkg::TPTIS_MAX_BUSY))
		else $error("busy held too long");
	chk_busy_set: assert property (@(posedge SYS_CLK_I) // [RL5]
		disable iff (SYS_RST_I) (wr_addr && !busy) |=> busy)
		else $error("busy not set on start");
	chk_busy_clear: assert property (@(posedge SYS_CLK_I) // [RL2]
		disable iff (SYS_RST_I) (wr_addr && !busy) |=> busy[*5] ##1 !busy)
		else $error("transfer length wrong");
	chk_read_copy: assert property (@(posedge SYS_CLK_I) // [RL3]
		disable iff (SYS_RST_I) (fin && rnw_reg && path_ok && is_cfg)
		|=> data_reg == {13'h0000, $past(cfg_mem[pidx])})
		else $error("config read not copied");
	chk_invalid_loc: assert property (@(posedge SYS_CLK_I) // [RL20]
		disable iff (SYS_RST_I) (fin && rnw_reg && !(is_cfg || is_msg))
		|=> $stable(data_reg))
		else $error("invalid read changed data");
	chk_data_hi: assert property (@(posedge SYS_CLK_I) // [RL16]
		disable iff (SYS_RST_I) (fin && rnw_reg && path_ok && is_msg)
		|=> data_reg[15:8] == 8'h00)
		else $error("trace byte upper bits set");
	chk_zero_msg: assert property (@(posedge SYS_CLK_I) // [RL12]
		disable iff (SYS_RST_I) (TRACE_SLOT_I && tp_ok
		&& tcfg[tptis_pkg::TPTIS_CFG_ZERO]) |=> TRACE_BYTE_O == 8'h00)
		else $error("zero message not sent");
	chk_single_pos: assert property (@(posedge SYS_CLK_I) // [RL11]
		disable iff (SYS_RST_I) (TRACE_SLOT_I && tp_ok
		&& tcfg[tptis_pkg::TPTIS_CFG_SINGLE]) |-> tpos == 6'h00)
		else $error("single byte position moved");
	chk_ack_once: assert property (@(posedge SYS_CLK_I)
		disable iff (SYS_RST_I) WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");

	//------------------------------------------------------------
	// Bus handshake checks
	//------------------------------------------------------------
	// Ack latency is fixed at one cycle; masters may rely on it

	chk_ack_follows: assert property (@(posedge SYS_CLK_I)
		disable iff (SYS_RST_I) req |=> WB_ACK_O)
		else $error("request not acknowledged");

	chk_ack_cause: assert property (@(posedge SYS_CLK_I)
		disable iff (SYS_RST_I) WB_ACK_O |-> $past(req))
		else $error("ack without request");

	//------------------------------------------------------------
	// Indirect transfer checks
	//------------------------------------------------------------
	// Engine leaves idle only on an accepted address write

	chk_idle_hold: assert property (@(posedge SYS_CLK_I) // [RL5]
		disable iff (SYS_RST_I) (!busy && !wr_addr) |=> !busy)
		else $error("busy rose without start");

	// A late start must not disturb the access in flight
	chk_start_ignored: assert property (@(posedge SYS_CLK_I) // [RL2]
		disable iff (SYS_RST_I) (wr_addr && busy)
		|=> $stable(loc_reg) && $stable(path_reg))
		else $error("fields changed while busy");

	chk_cfg_write: assert property (@(posedge SYS_CLK_I) // [RL4] [RL15]
		disable iff (SYS_RST_I) (fin && !rnw_reg && path_ok && is_cfg)
		|=> cfg_mem[pidx] == $past(data_reg[2:0]))
		else $error("config write lost");

	chk_msg_write: assert property (@(posedge SYS_CLK_I) // [RL4] [RL16]
		disable iff (SYS_RST_I) (fin && !rnw_reg && path_ok && is_msg)
		|=> msg_mem[midx] == $past(data_reg[7:0]))
		else $error("trace byte write lost");

	chk_bad_path: assert property (@(posedge SYS_CLK_I) // [RL20]
		disable iff (SYS_RST_I) (fin && rnw_reg && !path_ok)
		|=> $stable(data_reg))
		else $error("invalid path read changed data");

	//------------------------------------------------------------
	// Trace stream checks
	//------------------------------------------------------------
	// Valid is one cycle behind the slot and never spontaneous

	chk_valid_slot: assert property (@(posedge SYS_CLK_I) // [RL21]
		disable iff (SYS_RST_I) (TRACE_SLOT_I && tp_ok)
		|=> TRACE_VALID_O)
		else $error("slot not answered");

	chk_valid_idle: assert property (@(posedge SYS_CLK_I) // [RL21]
		disable iff (SYS_RST_I) !(TRACE_SLOT_I && tp_ok)
		|=> !TRACE_VALID_O)
		else $error("valid without slot");

	chk_msg_byte: assert property (@(posedge SYS_CLK_I) // [RL14]
		disable iff (SYS_RST_I) (TRACE_SLOT_I && tp_ok
		&& !tcfg[tptis_pkg::TPTIS_CFG_ZERO])
		|=> TRACE_BYTE_O == $past(msg_mem[tmi]))
		else $error("wrong trace byte sent");

	//------------------------------------------------------------
	// Coverage
	//------------------------------------------------------------
	cov_read: cover property (@(posedge SYS_CLK_I) fin && rnw_reg);
	cov_zero: cover property (@(posedge SYS_CLK_I)
		TRACE_SLOT_I && tp_ok && tcfg[tptis_pkg::TPTIS_CFG_ZERO]);
	cov_invalid: cover property (@(posedge SYS_CLK_I)
		fin && !(path_ok && (is_cfg || is_msg)));
	cov_write: cover property (@(posedge SYS_CLK_I) fin && !rnw_reg);
	cov_wrap: cover property (@(posedge SYS_CLK_I)
		TRACE_SLOT_I && tp_ok && tpos == last && last != 6'h00);
endmodule // tptis_store

// ### tb/tptis_store_bench.sv
// Self-checking bench for the indirect trace store
`timescale 1ns/1ps
module tptis_store_bench;
	localparam logic [15:0] adr_idx = tptis_pkg::TPTIS_ADDR_OFS;
	localparam logic [15:0] dat_idx = tptis_pkg::TPTIS_DATA_OFS;
	logic clk, rst, cyc, stb, we, slot, ack, tvalid;
	logic [15:0] adr;
	logic [3:0] sel, tpath;
	logic [31:0] wdat, rdat, r;
	logic [7:0] tbyte;
	int failures, n_compared, cycles;

	tptis_store i_tptis_store (.SYS_CLK_I(clk), .SYS_RST_I(rst),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.TRACE_SLOT_I(slot), .TRACE_PATH_I(tpath), .TRACE_BYTE_O(tbyte),
		.TRACE_VALID_O(tvalid));

	//------------------------------------------------------------
	// Clock and hang guard
	//------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Full run needs roughly a thousand cycles; generous margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("unexpected at %0t: timeout", $time);
			wrap_up();
		end
	end

	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Ack and read data taken at the rising edge that sees ack high
	task automatic wb(input logic w, input logic [15:0] idx,
		input logic [15:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= idx << 2;
		wdat <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic xfer(input logic rnw, input logic [6:0] loc,
		input logic [3:0] p);
		logic [15:0] f;
		f = {1'b0, rnw, 1'b0, loc, 2'b00, p};
		wb(1'b1, adr_idx, f);
		wb(1'b0, adr_idx, 16'h0000);
		check(r[15], 32'h1, "busy set");
		for (int i = 0; i < 8 && r[15] === 1'b1; i++) wb(1'b0, adr_idx, 16'h0);
		check(r, {16'h0000, f}, "busy clear and fields");
	endtask
	task automatic slot_chk(input logic [3:0] p, input logic [7:0] e);
		@(posedge clk);
		slot <= 1'b1;
		tpath <= p;
		@(posedge clk);
		slot <= 1'b0;
		@(negedge clk);
		check({tvalid, tbyte}, {1'b1, e}, "trace byte");
	endtask
	task automatic cfg(input logic [3:0] p, input logic [15:0] v);
		wb(1'b1, dat_idx, v);
		xfer(1'b0, 7'h00, p);
	endtask

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic t_reset;
		wb(1'b0, dat_idx, 16'h0000);
		check(r, 32'h0, "data reset");
		wb(1'b0, adr_idx, 16'h0000);
		check(r, 32'h0, "address reset");
		wb(1'b0, 16'h0123, 16'h0000);
		check(r, 32'h0, "unmapped read");
		$display("test reset done");
	endtask
	task automatic t_rw;
		wb(1'b1, dat_idx, 16'h00a5);
		xfer(1'b0, 7'h40, 4'h1);
		wb(1'b1, dat_idx, 16'h0000);
		xfer(1'b1, 7'h40, 4'h1);
		wb(1'b0, dat_idx, 16'h0000);
		check(r, 32'h00a5, "read back");
		wb(1'b1, dat_idx, 16'h005a);
		xfer(1'b0, 7'h40, 4'h0);
		xfer(1'b0, 7'h40, 4'hd);
		xfer(1'b0, 7'h01, 4'h1);
		xfer(1'b1, 7'h40, 4'h1);
		wb(1'b0, dat_idx, 16'h0000);
		check(r, 32'h00a5, "invalid writes ignored");
		wb(1'b1, dat_idx, 16'h005a);
		xfer(1'b1, 7'h3f, 4'h1);
		wb(1'b0, dat_idx, 16'h0000);
		check(r, 32'h005a, "invalid read ignored");
		$display("test indirect access done");
	endtask
	task automatic t_msg;
		for (int i = 0; i < 64; i++) begin
			wb(1'b1, dat_idx, {8'h00, 8'h30 + 8'(i)});
			xfer(1'b0, 7'h40 + 7'(i), 4'h2);
		end
		for (int i = 0; i < 66; i++) slot_chk(4'h2, 8'h30 + 8'(i % 64));
		cfg(4'h2, 16'h0001);
		// Position 2 survives the shrink since it is inside the new length
		for (int i = 0; i < 18; i++) slot_chk(4'h2, 8'h30 + 8'((i + 2) % 16));
		cfg(4'h2, 16'h0003);
		for (int i = 0; i < 3; i++) slot_chk(4'h2, 8'h30);
		cfg(4'h2, 16'h0007);
		xfer(1'b1, 7'h00, 4'h2);
		wb(1'b0, dat_idx, 16'h0000);
		check(r, 32'h0007, "config read back");
		slot_chk(4'h2, 8'h00);
		cfg(4'h2, 16'h0003);
		slot_chk(4'h2, 8'h30);
		$display("test message stream done");
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 16'h0000;
		sel = 4'hf;
		wdat = 32'h0;
		slot = 1'b0;
		tpath = 4'h0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_rw();
		t_msg();
		wrap_up();
	end
endmodule // tptis_store_bench
